// *** dv/ahb_host_model.sv ***
// Single-transfer AHB-Lite master standing in for the decoder side.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module ahb_host_model (
    input wire sys_clk,
    input wire hready,
    input wire [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // Data bus flips once released so a stale value never looks valid
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : ~hwdata;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule

// *** dv/bit_test_shift_datapath_tb_top.sv ***
// Self-checking bench for the bit-test and shift datapath.
// Assumes the host model drives the bus; hready loops from hreadyout.
`timescale 1ns/1ps
module bit_test_shift_datapath_tb_top;
    logic sys_clk;
    logic rstn;
    wire hsel, hwrite, hreadyout, hresp, global_irq_enable;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [7:0] status_flags;
    int n_errors;
    int n_compared;
    ahb_host_model i_host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    bit_test_shift_datapath i_dut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .status_flags(status_flags), .global_irq_enable(global_irq_enable));
    // ----
    // Helpers
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        i_host.xfer(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        i_host.xfer(1'b0, a, 32'h0000_0000, rd);
        check(rd, exp);
    endtask
    task automatic cmd(input logic [4:0] op, input logic [2:0] b, input logic [4:0] io);
        wr(12'h000, {11'h000, io, 5'h00, b, 3'h0, op});
    endtask
    // Result in [15:8], new flags in [7:0]
    function automatic logic [15:0] shift_ref(input logic [4:0] op, input logic [7:0] d, input logic [7:0] sr);
        logic [7:0] r;
        logic c;
        case (op)
            5'h02: {c, r} = {d, 1'b0};
            5'h03: {r, c} = {1'b0, d};
            5'h04: {c, r} = {d, sr[0]};
            5'h05: {r, c} = {sr[0], d};
            default: {r, c} = {d[7], d};
        endcase
        return {r, sr[7:4], r[7] ^ c, r[7], r == 8'h00, c};
    endfunction
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd_chk(12'h00C, 32'h0000_0000);
        rd_chk(12'h008, 32'h0000_0000);
        rd_chk(12'h0FC, 32'h0000_0000);
        check({hresp, global_irq_enable, status_flags}, 10'h000);
    endtask
    task automatic t_shifts();
        logic [15:0] e;
        for (int op = 2; op <= 6; op++) begin
            for (int k = 0; k < 2; k++) begin
                e = shift_ref(op[4:0], k ? 8'h81 : 8'h80, k ? 8'h71 : 8'h8E);
                wr(12'h004, k ? 32'h81 : 32'h80);
                wr(12'h00C, k ? 32'h71 : 32'h8E);
                cmd(op[4:0], 3'h0, 5'h00);
                rd_chk(12'h008, {24'h00_0000, e[15:8]});
                check({24'h00_0000, status_flags}, {24'h00_0000, e[7:0]});
            end
        end
    endtask
    task automatic t_swap();
        wr(12'h004, 32'h3C);
        wr(12'h00C, 32'h5A);
        cmd(5'h07, 3'h0, 5'h00);
        rd_chk(12'h008, 32'hC3);
        rd_chk(12'h00C, 32'h5A);
    endtask
    task automatic t_io();
        wr(12'h00C, 32'h2B);
        wr(12'h094, 32'hA5);
        cmd(5'h00, 3'h6, 5'h05);
        rd_chk(12'h094, 32'hE5);
        cmd(5'h01, 3'h0, 5'h05);
        rd_chk(12'h094, 32'hE4);
        cmd(5'h00, 3'h7, 5'h1F);
        rd_chk(12'h0FC, 32'h80);
        rd_chk(12'h090, 32'h00);
        rd_chk(12'h00C, 32'h2B);
    endtask
    task automatic t_tbit();
        wr(12'h00C, 32'h00);
        wr(12'h004, 32'h08);
        cmd(5'h0A, 3'h3, 5'h00);
        check(status_flags, 8'h40);
        wr(12'h004, 32'h10);
        cmd(5'h0B, 3'h0, 5'h00);
        rd_chk(12'h008, 32'h11);
        wr(12'h004, 32'hF7);
        cmd(5'h0A, 3'h3, 5'h00);
        check(status_flags, 8'h00);
        wr(12'h004, 32'hFF);
        cmd(5'h0B, 3'h7, 5'h00);
        rd_chk(12'h008, 32'h7F);
    endtask
    task automatic t_flags();
        logic [2:0] fb [0:8] = '{3'd0, 3'd0, 3'd2, 3'd2, 3'd1, 3'd1, 3'd7, 3'd7, 3'd4};
        logic [7:0] e = 8'h00;
        wr(12'h00C, 32'h00);
        for (int i = 0; i <= 8; i++) begin
            cmd(5'h0C + i[4:0], 3'h0, 5'h00);
            e[fb[i]] = (i == 8) || !i[0];
            check({global_irq_enable, status_flags}, {e[7], e});
        end
        for (int b = 0; b < 16; b++) begin
            cmd(b < 8 ? 5'h08 : 5'h09, b[2:0], 5'h00);
            e[b[2:0]] = b < 8;
            check(status_flags, e);
        end
    endtask
    task automatic t_misc();
        wr(12'h040, 32'hFFFF_FFFF);
        rd_chk(12'h040, 32'h0000_0000);
        wr(12'h00C, 32'h33);
        wr(12'h000, 32'h0005_071F);
        rd_chk(12'h010, 32'h0000_0001);
        rd_chk(12'h000, 32'h0005_071F);
        rd_chk(12'h00C, 32'h33);
    endtask
    // ----
    // Run control
    // ----
    task automatic complete_run();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Whole run is a few hundred cycles
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial begin
        rstn = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_shifts();
        t_swap();
        t_io();
        t_tbit();
        t_flags();
        t_misc();
        complete_run();
    end
endmodule

// *** dv/bts_props.sv ***
// Port checker for the bit-test and shift datapath.
// Assumes hready is looped back from hreadyout.
`timescale 1ns/1ps
module bts_checker (
    input wire sys_clk,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire [7:0] status_flags,
    input wire global_irq_enable
);
    // ----
    // Command launch
    // ----
    wire cw = hsel && htrans[1] && hready && hwrite && (haddr[11:0] == 12'h000);
    wire [4:0] op = hwdata[4:0];
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_IO_BIT_TIMING: assert property (cw ##1 op <= 5'h01 |-> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("io bit command length wrong");
    AST_IO_FLAGS_KEPT: assert property (cw ##1 op <= 5'h01 |=> $stable(status_flags) [*2])
        else $error("io bit command touched flags");
    AST_ONE_CYCLE: assert property (cw ##1 op >= 5'h02 && op <= 5'h14 |-> !hreadyout ##1 hreadyout)
        else $error("single cycle command length wrong");
    AST_SHIFT_KEEPS_UPPER: assert property (cw ##1 op >= 5'h02 && op <= 5'h06
        |=> status_flags[7:4] == $past(status_flags[7:4]))
        else $error("shift changed flags beyond ZCNV");
    AST_FLAGS_UNTOUCHED: assert property (cw ##1 (op == 5'h07 || op == 5'h0B) |=> $stable(status_flags))
        else $error("swap or load bit changed flags");
    AST_STORE_T_ONLY: assert property (cw ##1 op == 5'h0A
        |=> {status_flags[7], status_flags[5:0]} == {$past(status_flags[7]), $past(status_flags[5:0])})
        else $error("store bit changed other flags");
    AST_INDEXED_SET: assert property (cw ##1 op == 5'h08 |=> status_flags[$past(hwdata[10:8])])
        else $error("indexed flag set failed");
    AST_INDEXED_CLEAR: assert property (cw ##1 op == 5'h09 |=> !status_flags[$past(hwdata[10:8])])
        else $error("indexed flag clear failed");
    AST_SET_C: assert property (cw ##1 op == 5'h0C
        |=> status_flags[0] && status_flags[7:1] == $past(status_flags[7:1]))
        else $error("carry set failed");
    // Enable and disable codes differ only in bit 0
    AST_IRQ_OP: assert property (cw ##1 (op == 5'h12 || op == 5'h13)
        |=> global_irq_enable == !$past(hwdata[0]))
        else $error("irq enable op failed");
endmodule

bind bit_test_shift_datapath bts_checker i_chk (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .status_flags(status_flags), .global_irq_enable(global_irq_enable));

// *** hw/bit_test_shift_datapath.v ***
// Bit-test, shift and status-flag datapath behind an AHB-Lite register slave.
// Assumes a single AHB-Lite master; hready is this slave's own hreadyout.
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "bit_test_shift_datapath_regs.vh"

module bit_test_shift_datapath (
    input wire sys_clk,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output wire [7:0] status_flags,
    output wire global_irq_enable
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RMW = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg dp_write_reg;
    reg [11:0] dp_addr_reg;
    reg [7:0] operand_reg;
    reg [7:0] result_reg;
    reg [7:0] status_reg;
    reg [31:0] ctrl_reg;
    reg bad_op_reg;
    reg [4:0] rmw_addr_reg;
    reg [2:0] rmw_bit_reg;
    reg rmw_set_reg;

    wire accept;
    wire [7:0] mem_rdata;
    reg [4:0] mem_addr;
    reg mem_we;
    reg [7:0] mem_wdata;

    reg [4:0] cmd_op;
    reg [2:0] cmd_bit;
    reg [8:0] sc;
    reg [7:0] ex_sr;
    reg [7:0] ex_res;
    reg ex_res_we;
    reg ex_rmw;
    reg ex_bad;
    reg [31:0] rd_word;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [7:0] bit_mask;
        input [2:0] idx;
        begin
            bit_mask = 8'h01 << idx;
        end
    endfunction

    function is_io;
        input [11:0] a;
        begin
            is_io = (a[11:7] == `BTS_IO_SEL);
        end
    endfunction

    // Returns {carry_out, result}
    function [8:0] shift_calc;
        input [4:0] op;
        input [7:0] rd;
        input c;
        begin
            case (op)
                `BTS_OP_SHIFT_LEFT: shift_calc = {rd[7], rd[6:0], 1'b0};
                `BTS_OP_SHIFT_RIGHT: shift_calc = {rd[0], 1'b0, rd[7:1]};
                `BTS_OP_ROTATE_LEFT: shift_calc = {rd[7], rd[6:0], c};
                `BTS_OP_ROTATE_RIGHT: shift_calc = {rd[0], c, rd[7:1]};
                `BTS_OP_ARITH_RIGHT: shift_calc = {rd[0], rd[7], rd[7:1]};
                default: shift_calc = {c, rd};
            endcase
        end
    endfunction

    // Only Z, C, N, V move; S and H stay as they were
    function [7:0] shift_flags;
        input [7:0] sr;
        input [8:0] cr;
        reg [7:0] f;
        begin
            f = sr;
            f[`BTS_FLAG_Z] = (cr[7:0] == 8'h00);
            f[`BTS_FLAG_C] = cr[8];
            f[`BTS_FLAG_N] = cr[7];
            f[`BTS_FLAG_V] = cr[7] ^ cr[8];
            shift_flags = f;
        end
    endfunction

    assign accept = hsel & htrans[1] & hready;
    assign status_flags = status_reg;
    assign global_irq_enable = status_reg[`BTS_FLAG_I];

    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    always @* begin
        cmd_op = hwdata[`BTS_CTRL_OP_MSB:`BTS_CTRL_OP_LSB];
        cmd_bit = hwdata[`BTS_CTRL_BIT_MSB:`BTS_CTRL_BIT_LSB];
        sc = shift_calc(cmd_op, operand_reg, status_reg[`BTS_FLAG_C]);
        ex_sr = status_reg;
        ex_res = operand_reg;
        ex_res_we = 1'b0;
        ex_rmw = 1'b0;
        ex_bad = 1'b0;
        case (cmd_op)
            `BTS_OP_SET_IO_BIT, `BTS_OP_CLEAR_IO_BIT: begin
                ex_rmw = 1'b1;
            end
            `BTS_OP_SHIFT_LEFT, `BTS_OP_SHIFT_RIGHT, `BTS_OP_ROTATE_LEFT, `BTS_OP_ROTATE_RIGHT, `BTS_OP_ARITH_RIGHT: begin
                ex_res = sc[7:0];
                ex_res_we = 1'b1;
                ex_sr = shift_flags(status_reg, sc);
            end
            `BTS_OP_SWAP: begin
                ex_res = {operand_reg[3:0], operand_reg[7:4]};
                ex_res_we = 1'b1;
            end
            `BTS_OP_STATUS_SET: begin
                ex_sr = status_reg | bit_mask(cmd_bit);
            end
            `BTS_OP_STATUS_CLEAR: begin
                ex_sr = status_reg & ~bit_mask(cmd_bit);
            end
            `BTS_OP_STORE_T: begin
                ex_sr[`BTS_FLAG_T] = operand_reg[cmd_bit];
            end
            `BTS_OP_LOAD_T: begin
                ex_res[cmd_bit] = status_reg[`BTS_FLAG_T];
                ex_res_we = 1'b1;
            end
            `BTS_OP_SET_C: begin
                ex_sr[`BTS_FLAG_C] = 1'b1;
            end
            `BTS_OP_CLEAR_C: begin
                ex_sr[`BTS_FLAG_C] = 1'b0;
            end
            `BTS_OP_SET_N: begin
                ex_sr[`BTS_FLAG_N] = 1'b1;
            end
            `BTS_OP_CLEAR_N: begin
                ex_sr[`BTS_FLAG_N] = 1'b0;
            end
            `BTS_OP_SET_Z: begin
                ex_sr[`BTS_FLAG_Z] = 1'b1;
            end
            `BTS_OP_CLEAR_Z: begin
                ex_sr[`BTS_FLAG_Z] = 1'b0;
            end
            `BTS_OP_IRQ_ENABLE: begin
                ex_sr[`BTS_FLAG_I] = 1'b1;
            end
            `BTS_OP_IRQ_DISABLE: begin
                ex_sr[`BTS_FLAG_I] = 1'b0;
            end
            `BTS_OP_SET_S: begin
                ex_sr[`BTS_FLAG_S] = 1'b1;
            end
            default: begin
                ex_bad = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // I/O space port steering
    // ----------------------------------------
    // One port only; writes run while hready is low so no read can collide
    always @* begin
        mem_we = 1'b0;
        mem_wdata = hwdata[7:0];
        mem_addr = haddr[6:2];
        case (state_reg)
            ST_RMW: begin
                mem_addr = rmw_addr_reg;
                mem_we = 1'b1;
                if (rmw_set_reg) begin
                    mem_wdata = mem_rdata | bit_mask(rmw_bit_reg);
                end else begin
                    mem_wdata = mem_rdata & ~bit_mask(rmw_bit_reg);
                end
            end
            ST_WAIT: begin
                if (dp_write_reg && dp_addr_reg == `BTS_OFF_CTRL) begin
                    mem_addr = hwdata[`BTS_CTRL_IO_MSB:`BTS_CTRL_IO_LSB];
                end else begin
                    mem_addr = dp_addr_reg[6:2];
                    mem_we = dp_write_reg & is_io(dp_addr_reg);
                end
            end
            ST_IDLE: begin
                mem_addr = haddr[6:2];
            end
            default: begin
                mem_addr = haddr[6:2];
            end
        endcase
    end

    io_space_mem u_io_space_mem (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always @* begin
        case (haddr[11:0])
            `BTS_OFF_CTRL: rd_word = ctrl_reg;
            `BTS_OFF_OPERAND: rd_word = {24'h00_0000, operand_reg};
            `BTS_OFF_RESULT: rd_word = {24'h00_0000, result_reg};
            `BTS_OFF_STATUS: rd_word = {24'h00_0000, status_reg};
            `BTS_OFF_INFO: rd_word = {31'h0000_0000, bad_op_reg};
            default: rd_word = `BTS_WORD_RST;
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept && (hwrite || is_io(haddr[11:0]))) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (dp_write_reg && dp_addr_reg == `BTS_OFF_CTRL && ex_rmw) begin
                    state_next = ST_RMW;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_RMW: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Bus slave and datapath registers
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            hrdata <= `BTS_WORD_RST;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 12'h000;
            operand_reg <= `BTS_OPERAND_RST;
            result_reg <= `BTS_RESULT_RST;
            status_reg <= `BTS_STATUS_RST;
            ctrl_reg <= `BTS_WORD_RST;
            bad_op_reg <= 1'b0;
            rmw_addr_reg <= 5'h00;
            rmw_bit_reg <= 3'h0;
            rmw_set_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hresp <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        dp_write_reg <= hwrite;
                        dp_addr_reg <= haddr[11:0];
                        if (hwrite || is_io(haddr[11:0])) begin
                            // Wait state keeps hrdata a flop and serialises the one I/O port
                            hreadyout <= 1'b0;
                        end else begin
                            hrdata <= rd_word;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!dp_write_reg) begin
                        hrdata <= {24'h00_0000, mem_rdata};
                        hreadyout <= 1'b1;
                    end else begin
                        hreadyout <= ~(dp_addr_reg == `BTS_OFF_CTRL && ex_rmw);
                        case (dp_addr_reg)
                            `BTS_OFF_CTRL: begin
                                ctrl_reg <= hwdata;
                                bad_op_reg <= ex_bad;
                                status_reg <= ex_sr;
                                if (ex_res_we) begin
                                    result_reg <= ex_res;
                                end
                                rmw_addr_reg <= hwdata[`BTS_CTRL_IO_MSB:`BTS_CTRL_IO_LSB];
                                rmw_bit_reg <= cmd_bit;
                                rmw_set_reg <= (cmd_op == `BTS_OP_SET_IO_BIT);
                            end
                            `BTS_OFF_OPERAND: begin
                                operand_reg <= hwdata[7:0];
                            end
                            `BTS_OFF_STATUS: begin
                                status_reg <= hwdata[7:0];
                            end
                            default: begin
                                result_reg <= result_reg;
                            end
                        endcase
                    end
                end
                ST_RMW: begin
                    // Second cycle of the I/O bit op; flags untouched
                    result_reg <= mem_wdata;
                    hreadyout <= 1'b1;
                end
                default: begin
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

endmodule

// *** hw/bit_test_shift_datapath_regs.vh ***
// Constants for the bit-test and shift datapath: offsets, fields, codes, resets.
// Assumes an AHB-Lite slave decode on the low twelve address bits.
//
// Notes on behaviour
// - set_io_bit forces one I/O bit high, others and flags kept, two cycles.
// - clear_io_bit forces one I/O bit low, others and flags kept, two cycles.
// - logical_shift_left moves bits up, zero into bit 0, updates Z C N V, one cycle.
// - logical_shift_right moves bits down, zero into bit 7, updates Z C N V, one cycle.
// - rotate_left_through_carry: old carry to bit 0, bit 7 to carry, Z C N V.
// - rotate_right_through_carry: old carry to bit 7, bit 0 to carry, Z C N V.
// - arithmetic_shift_right loads bits 0..6 from next higher bit, Z C N V, one cycle.
// - store_bit_to_transfer_flag copies chosen source bit into T only, one cycle.
// - load_bit_from_transfer_flag copies T into chosen bit, flags untouched, one cycle.
// - Flag set and clear ops force one status bit, others unchanged, one cycle.

`ifndef BIT_TEST_SHIFT_DATAPATH_REGS_VH
`define BIT_TEST_SHIFT_DATAPATH_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BTS_OFF_CTRL 12'h000
`define BTS_OFF_OPERAND 12'h004
`define BTS_OFF_RESULT 12'h008
`define BTS_OFF_STATUS 12'h00C
`define BTS_OFF_INFO 12'h010
`define BTS_IO_BASE 12'h080
`define BTS_IO_SEL 5'h01

// ----------------------------------------
// Command word fields
// ----------------------------------------
`define BTS_CTRL_OP_LSB 0
`define BTS_CTRL_OP_MSB 4
`define BTS_CTRL_BIT_LSB 8
`define BTS_CTRL_BIT_MSB 10
`define BTS_CTRL_IO_LSB 16
`define BTS_CTRL_IO_MSB 20

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define BTS_OP_SET_IO_BIT 5'h00
`define BTS_OP_CLEAR_IO_BIT 5'h01
`define BTS_OP_SHIFT_LEFT 5'h02
`define BTS_OP_SHIFT_RIGHT 5'h03
`define BTS_OP_ROTATE_LEFT 5'h04
`define BTS_OP_ROTATE_RIGHT 5'h05
`define BTS_OP_ARITH_RIGHT 5'h06
`define BTS_OP_SWAP 5'h07
`define BTS_OP_STATUS_SET 5'h08
`define BTS_OP_STATUS_CLEAR 5'h09
`define BTS_OP_STORE_T 5'h0A
`define BTS_OP_LOAD_T 5'h0B
`define BTS_OP_SET_C 5'h0C
`define BTS_OP_CLEAR_C 5'h0D
`define BTS_OP_SET_N 5'h0E
`define BTS_OP_CLEAR_N 5'h0F
`define BTS_OP_SET_Z 5'h10
`define BTS_OP_CLEAR_Z 5'h11
`define BTS_OP_IRQ_ENABLE 5'h12
`define BTS_OP_IRQ_DISABLE 5'h13
`define BTS_OP_SET_S 5'h14

// ----------------------------------------
// Status register bit positions
// ----------------------------------------
`define BTS_FLAG_C 0
`define BTS_FLAG_Z 1
`define BTS_FLAG_N 2
`define BTS_FLAG_V 3
`define BTS_FLAG_S 4
`define BTS_FLAG_H 5
`define BTS_FLAG_T 6
`define BTS_FLAG_I 7

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define BTS_STATUS_RST 8'h00
`define BTS_OPERAND_RST 8'h00
`define BTS_RESULT_RST 8'h00
`define BTS_WORD_RST 32'h0000_0000
`define BTS_CYC_IO_BIT 2
`define BTS_CYC_SINGLE 1

`endif

// *** hw/io_space_mem.v ***
// Thirty-two byte I/O register space with one port and registered read data.
// Assumes one access per cycle; write and read share the address.
`timescale 1ns/1ps

module io_space_mem (
    input wire sys_clk,
    input wire rstn,
    input wire [4:0] addr,
    input wire we,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);

    reg [7:0] mem_reg [0:31];
    integer i;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Read returns old data during a write
    always @(posedge sys_clk) begin
        if (!rstn) begin
            for (i = 0; i < 32; i = i + 1) begin
                mem_reg[i] <= 8'h00;
            end
            rdata <= 8'h00;
        end else begin
            if (we) begin
                mem_reg[addr] <= wdata;
            end
            rdata <= mem_reg[addr];
        end
    end

endmodule
